//--- design/fgpio_top.v
// Purpose: Three-port fast GPIO block with an AXI4-Lite register slave.
// Assumes: All pins are synchronous to I_SYS_CLK; the reset is synchronous.
// Notes: Ports 0 and 2 carry edge interrupts; ports 0 and 1 have a legacy window.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fgpio_consts.vh"
module fgpio_top (
  input  wire        I_SYS_CLK,
  input  wire        I_RST,
  input  wire [31:0] I_AWADDR,
  input  wire        I_AWVALID,
  output reg         O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output reg         O_WREADY,
  output reg  [1:0]  O_BRESP,
  output reg         O_BVALID,
  input  wire        I_BREADY,
  input  wire [31:0] I_ARADDR,
  input  wire        I_ARVALID,
  output reg         O_ARREADY,
  output reg  [31:0] O_RDATA,
  output reg  [1:0]  O_RRESP,
  output reg         O_RVALID,
  input  wire        I_RREADY,
  input  wire [95:0] I_PIN_IN,
  input  wire [95:0] I_PERIPH_SEL,
  input  wire [95:0] I_PERIPH_OUT,
  input  wire [95:0] I_PERIPH_OE,
  input  wire [63:0] I_ANALOG_SEL,
  input  wire        I_EXT_IRQ3,
  output wire [95:0] O_PIN_OUT,
  output wire [95:0] O_PIN_OE,
  output reg         O_SHARED_EXTERNAL_IRQ_LINE,
  output reg         O_WAKE
);
  wire [31:0] port_rdata [0:2];
  wire [2:0]  port_irq;
  wire [95:0] analog_all = {I_ANALOG_SEL[63:32], 32'h0000_0000, I_ANALOG_SEL[31:0]};

  // Address decode shared by both channels.
  reg  [1:0]  w_port, r_port;
  reg  [3:0]  w_idx, r_idx;
  reg         w_ok, r_ok, w_leg, r_leg;
  reg  [1:0]  dp;
  reg  [3:0]  di;
  reg         dok, dleg;

  task decode;
    input  [31:0] a;
    output [1:0]  port;
    output [3:0]  idx;
    output        ok;
    output        leg;
    begin
      port = 2'h0;
      idx  = 4'h0;
      ok   = 1'b0;
      leg  = 1'b0;
      if (a[31:9] == 23'h000000 && a[1:0] == 2'h0)
      begin
        if (a[8])
        begin
          // Legacy copies ignore the mask, as older software expects.
          leg  = 1'b1;
          port = {1'b0, a[5]};
          ok   = (a[7:6] == 2'h0) && (a[4] == 1'b0);
          case (a[3:2])
            `FGP_LEG_PIN: idx = `FGP_IDX_PIN;
            `FGP_LEG_SET: idx = `FGP_IDX_SET;
            `FGP_LEG_DIR: idx = `FGP_IDX_DIR;
            `FGP_LEG_CLR: idx = `FGP_IDX_CLR;
            default:      idx = `FGP_IDX_PIN;
          endcase
        end
        else
        begin
          port = a[7:6];
          idx  = a[5:2];
          if (a[7:6] == 2'h1)
            ok = (a[5:2] <= `FGP_IDX_LAST);
          else
            ok = (a[7:6] != 2'h3) && (a[5:2] <= `FGP_IDX_LAST_IRQ);
        end
      end
    end
  endtask

  always @*
  begin
    decode(I_AWADDR, dp, di, dok, dleg);
    w_port = dp;
    w_idx  = di;
    w_ok   = dok;
    w_leg  = dleg;
  end

  reg  [1:0]  rp;
  reg  [3:0]  ri;
  reg         rok, rleg;
  always @*
  begin
    decode(I_ARADDR, rp, ri, rok, rleg);
    r_port = rp;
    r_idx  = ri;
    r_ok   = rok;
    r_leg  = rleg;
  end

  // Write channel: both address and data are taken in the same cycle.
  wire wr_go = I_AWVALID && I_WVALID && !O_BVALID && !O_AWREADY;
  wire rd_go = I_ARVALID && !O_RVALID && !O_ARREADY;

  always @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= `FGP_RESP_OKAY;
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RRESP   <= `FGP_RESP_OKAY;
      O_RDATA   <= 32'h0000_0000;
    end
    else
    begin
      O_AWREADY <= wr_go;
      O_WREADY  <= wr_go;
      if (wr_go)
      begin
        O_BVALID <= 1'b1;
        O_BRESP  <= w_ok ? `FGP_RESP_OKAY : `FGP_RESP_SLVERR;
      end
      else if (I_BREADY)
        O_BVALID <= 1'b0;
      O_ARREADY <= rd_go;
      if (rd_go)
      begin
        O_RVALID <= 1'b1;
        O_RRESP  <= r_ok ? `FGP_RESP_OKAY : `FGP_RESP_SLVERR;
        // Legacy reads see the whole port since no mask applies there.
        O_RDATA  <= r_ok ? port_rdata[r_port] : 32'h0000_0000;
      end
      else if (I_RREADY)
        O_RVALID <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `FGP_NPORTS; g = g + 1)
    begin : g_port
      fgpio_port #(
        .HAS_IRQ (g != 1)
      ) u_port (
        .i_clk        (I_SYS_CLK),
        .i_rst        (I_RST),
        .i_wr_en      (wr_go && w_ok && (w_port == g)),
        .i_no_mask    (w_leg),
        .i_wr_idx     (w_idx),
        .i_wdata      (I_WDATA),
        .i_wstrb      (I_WSTRB),
        .i_rd_idx     (r_idx),
        .i_rd_no_mask (r_leg),
        .i_pin_in     (I_PIN_IN[g*32 +: 32]),
        .i_periph_sel (I_PERIPH_SEL[g*32 +: 32]),
        .i_periph_out (I_PERIPH_OUT[g*32 +: 32]),
        .i_periph_oe  (I_PERIPH_OE[g*32 +: 32]),
        .i_analog     (analog_all[g*32 +: 32]),
        .o_rdata      (port_rdata[g]),
        .o_pin_out    (O_PIN_OUT[g*32 +: 32]),
        .o_pin_oe     (O_PIN_OE[g*32 +: 32]),
        .o_irq        (port_irq[g])
      );
    end
  endgenerate

  // Edge capture runs from the system clock here; a true clockless capture
  // cell would sit in the pad ring, and this flag is its stand-in.
  always @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_SHARED_EXTERNAL_IRQ_LINE <= 1'b0;
      O_WAKE                     <= 1'b0;
    end
    else
    begin
      O_SHARED_EXTERNAL_IRQ_LINE <= port_irq[0] | port_irq[2] | I_EXT_IRQ3;
      O_WAKE                     <= port_irq[0] | port_irq[2];
    end
  end
endmodule // fgpio_top

//--- inc/fgpio_consts.vh
// Purpose: Constants for the fast GPIO port with edge interrupts.
// Assumes: Included by fgpio_top.v and fgpio_port.v by bare name.
// Notes: Byte offsets are relative to the block base address.
// Function
// - Pins assigned to a peripheral follow that peripheral, not the port registers.
// - Software sets each pin's direction bit by bit at any time.
// - Dedicated set and clear registers change many output bits in one write.
// - Software reads the output latch and, separately, the sampled pin levels.
// - A mask register limits reads and writes to unmasked bit positions; here reads of the output latch (FGP_IDX_OUT) ignore the mask.
// - Byte, half-word and word accesses affect only the addressed byte lanes.
// - One write can update a whole port's output value.
// - Ports 0 and 2 pins, unless analog, interrupt on rising, falling or both.
// - Edge capture must work without a running clock in power-down; here edges are sampled on i_clk.
// - Any enabled pin edge interrupt can wake the chip from power-down.
// - After reset every pin is an input with its driver off.
// - A legacy copy of port 0 and port 1 controls sits at historic addresses.
// - Port 0 and 2 edge requests merge onto the shared external interrupt line.
`ifndef FGPIO_CONSTS_VH
`define FGPIO_CONSTS_VH

`define FGP_NPORTS        3
`define FGP_WIDTH         32
`define FGP_PORT_STRIDE   32'h0000_0040
`define FGP_LEG_BASE      32'h0000_0100
`define FGP_LEG_STRIDE    32'h0000_0020

// Register index inside one port window; byte offset is four times the index.
`define FGP_IDX_DIR       4'h0
`define FGP_IDX_MASK      4'h1
`define FGP_IDX_PIN       4'h2
`define FGP_IDX_SET       4'h3
`define FGP_IDX_CLR       4'h4
`define FGP_IDX_OUT       4'h5
`define FGP_IDX_RISE_EN   4'h6
`define FGP_IDX_FALL_EN   4'h7
`define FGP_IDX_RSTAT     4'h8
`define FGP_IDX_FSTAT     4'h9
`define FGP_IDX_RCLR      4'ha
`define FGP_IDX_FCLR      4'hb
`define FGP_IDX_LAST_IRQ  4'hb
`define FGP_IDX_LAST      4'h7

// Legacy window order: pin level, set, direction, clear.
`define FGP_LEG_PIN       2'h0
`define FGP_LEG_SET       2'h1
`define FGP_LEG_DIR       2'h2
`define FGP_LEG_CLR       2'h3

`define FGP_RST_WORD      32'h0000_0000
`define FGP_RESP_OKAY     2'h0
`define FGP_RESP_SLVERR   2'h2

`endif

//--- design/fgpio_port.v
// Purpose: One 32-pin GPIO port: direction, output latch, mask, edge capture.
// Assumes: Pins and peripheral controls are synchronous to i_clk.
// Notes: Edge logic is present only when HAS_IRQ is 1.
`timescale 1ns/1ps
`include "fgpio_consts.vh"
module fgpio_port #(
  parameter HAS_IRQ = 0
) (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_wr_en,
  input  wire        i_no_mask,
  input  wire [3:0]  i_wr_idx,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire [3:0]  i_rd_idx,
  input  wire        i_rd_no_mask,
  input  wire [31:0] i_pin_in,
  input  wire [31:0] i_periph_sel,
  input  wire [31:0] i_periph_out,
  input  wire [31:0] i_periph_oe,
  input  wire [31:0] i_analog,
  output reg  [31:0] o_rdata,
  output reg  [31:0] o_pin_out,
  output reg  [31:0] o_pin_oe,
  output wire        o_irq
);
  reg  [31:0] dir_reg, out_reg, mask_reg, rise_en_reg, fall_en_reg, rstat_reg, fstat_reg, pin_reg, prev_reg;
  wire [31:0] lane = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
  wire [31:0] mask = i_no_mask ? 32'h0000_0000 : mask_reg;
  // Legacy reads bypass the mask, so older software sees the whole port.
  wire [31:0] rd_mask = i_rd_no_mask ? 32'h0000_0000 : mask_reg;
  wire [31:0] wbits = i_wdata & lane & ~mask;
  wire [31:0] keep = ~lane | mask;
  wire [31:0] edge_ok = ~i_analog;
  wire [31:0] rise_ev = (HAS_IRQ != 0) ? (pin_reg & ~prev_reg & rise_en_reg & edge_ok) : 32'h0000_0000;
  wire [31:0] fall_ev = (HAS_IRQ != 0) ? (~pin_reg & prev_reg & fall_en_reg & edge_ok) : 32'h0000_0000;
  wire        we_rclr = i_wr_en && (i_wr_idx == `FGP_IDX_RCLR);
  wire        we_fclr = i_wr_en && (i_wr_idx == `FGP_IDX_FCLR);

  assign o_irq = |(rstat_reg | fstat_reg);

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dir_reg     <= `FGP_RST_WORD;
      out_reg     <= `FGP_RST_WORD;
      mask_reg    <= `FGP_RST_WORD;
      rise_en_reg <= `FGP_RST_WORD;
      fall_en_reg <= `FGP_RST_WORD;
      rstat_reg   <= `FGP_RST_WORD;
      fstat_reg   <= `FGP_RST_WORD;
      pin_reg     <= `FGP_RST_WORD;
      prev_reg    <= `FGP_RST_WORD;
      o_pin_out   <= `FGP_RST_WORD;
      o_pin_oe    <= `FGP_RST_WORD;
    end
    else
    begin
      pin_reg  <= i_pin_in;
      prev_reg <= pin_reg;
      if (i_wr_en)
      begin
        case (i_wr_idx)
          `FGP_IDX_DIR:     dir_reg <= (dir_reg & keep) | wbits;
          `FGP_IDX_MASK:    mask_reg <= (mask_reg & ~lane) | (i_wdata & lane);
          `FGP_IDX_PIN:     out_reg <= (out_reg & keep) | wbits;
          `FGP_IDX_SET:     out_reg <= out_reg | wbits;
          `FGP_IDX_CLR:     out_reg <= out_reg & ~wbits;
          `FGP_IDX_RISE_EN: rise_en_reg <= (rise_en_reg & ~lane) | (i_wdata & lane);
          `FGP_IDX_FALL_EN: fall_en_reg <= (fall_en_reg & ~lane) | (i_wdata & lane);
          default:          out_reg <= out_reg;
        endcase
      end
      // A new edge in the clearing cycle wins, so no event is lost.
      rstat_reg <= (rstat_reg & ~(we_rclr ? (i_wdata & lane) : 32'h0000_0000)) | rise_ev;
      fstat_reg <= (fstat_reg & ~(we_fclr ? (i_wdata & lane) : 32'h0000_0000)) | fall_ev;
      o_pin_out <= (i_periph_sel & i_periph_out) | (~i_periph_sel & out_reg);
      o_pin_oe  <= (i_periph_sel & i_periph_oe) | (~i_periph_sel & dir_reg);
    end
  end

  always @*
  begin
    case (i_rd_idx)
      `FGP_IDX_DIR:     o_rdata = dir_reg & ~rd_mask;
      `FGP_IDX_MASK:    o_rdata = mask_reg;
      `FGP_IDX_PIN:     o_rdata = pin_reg & ~rd_mask;
      `FGP_IDX_OUT:     o_rdata = out_reg;
      `FGP_IDX_RISE_EN: o_rdata = rise_en_reg;
      `FGP_IDX_FALL_EN: o_rdata = fall_en_reg;
      `FGP_IDX_RSTAT:   o_rdata = rstat_reg;
      `FGP_IDX_FSTAT:   o_rdata = fstat_reg;
      default:          o_rdata = 32'h0000_0000;
    endcase
  end
endmodule // fgpio_port

//--- tb/fgpio_chk.sv
// Purpose: Port checker for the fast GPIO block.
// Assumes: One clock and a synchronous active-high reset.
// Notes: The slave answers one cycle after it takes a request.
`timescale 1ns/1ps
module fgpio_chk (
  input wire        I_SYS_CLK,
  input wire        I_RST,
  input wire        I_AWVALID,
  input wire        I_WVALID,
  input wire        O_AWREADY,
  input wire        O_BVALID,
  input wire        I_BREADY,
  input wire        I_ARVALID,
  input wire        O_ARREADY,
  input wire        O_RVALID,
  input wire        I_RREADY,
  input wire        I_EXT_IRQ3,
  input wire [95:0] O_PIN_OE,
  input wire        O_SHARED_EXTERNAL_IRQ_LINE,
  input wire        O_WAKE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence s_wr_take;
    I_AWVALID && I_WVALID && !O_BVALID && !O_AWREADY;
  endsequence
  sequence s_rd_take;
    I_ARVALID && !O_RVALID && !O_ARREADY;
  endsequence
  a_write_answer: assert property (s_wr_take |=> O_AWREADY && O_BVALID)
    else $error("write not answered in one cycle");
  a_read_answer: assert property (s_rd_take |=> O_ARREADY && O_RVALID)
    else $error("read not answered in one cycle");
  a_bvalid_hold: assert property (O_BVALID |=> O_BVALID == !$past(I_BREADY))
    else $error("write response not held to its handshake");
  a_rvalid_hold: assert property (O_RVALID |=> O_RVALID == !$past(I_RREADY))
    else $error("read response not held to its handshake");
  a_awready_pulse: assert property (O_AWREADY |=> !O_AWREADY)
    else $error("write address ready longer than one cycle");
  a_reset_pin_input: assert property (disable iff (1'b0) I_RST |=> O_PIN_OE == 96'h0)
    else $error("pin driver on after reset");
  a_ext_irq_merge: assert property (I_EXT_IRQ3 |=> O_SHARED_EXTERNAL_IRQ_LINE)
    else $error("external request missing on shared line");
  a_wake_raises_irq: assert property ($rose(O_WAKE) |-> ##[0:2] O_SHARED_EXTERNAL_IRQ_LINE)
    else $error("wake without shared interrupt");
endmodule // fgpio_chk
bind fgpio_top fgpio_chk u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_AWVALID(I_AWVALID),
  .I_WVALID(I_WVALID), .O_AWREADY(O_AWREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .I_EXT_IRQ3(I_EXT_IRQ3), .O_PIN_OE(O_PIN_OE), .O_WAKE(O_WAKE),
  .O_SHARED_EXTERNAL_IRQ_LINE(O_SHARED_EXTERNAL_IRQ_LINE));

//--- tb/fgpio_board.sv
// Purpose: Board model driving the GPIO pin inputs.
// Assumes: A pin the block drives reads back its own drive.
// Notes: Released pins show the level the board holds.
`timescale 1ns/1ps
module fgpio_board (
  input  wire [95:0] i_out,
  input  wire [95:0] i_oe,
  input  wire [95:0] i_ext,
  output wire [95:0] o_pin
);
  assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule // fgpio_board

//--- tb/fgpio_top_tb.sv
// Purpose: Self-checking bench for the fast GPIO block.
// Assumes: AXI4-Lite master tasks; pins come from the board model.
// Notes: Expected values are worked out from the register map.
`timescale 1ns/1ps
module fgpio_top_tb;
  reg         clk;
  reg         rst;
  reg  [31:0] awaddr, wdata, araddr;
  reg  [3:0]  wstrb;
  reg         awvalid, wvalid, bready, arvalid, rready, ext3;
  reg  [95:0] ext, psel, pout, poe;
  reg  [63:0] ana;
  wire [95:0] pin_in, pin_out, pin_oe;
  wire [31:0] rdata;
  wire [1:0]  bresp, rresp;
  wire        awready, wready, bvalid, arready, rvalid, irq, wake;
  integer     n_errors, tests_run, k;
  fgpio_top uut (.I_SYS_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_PIN_IN(pin_in),
    .I_PERIPH_SEL(psel), .I_PERIPH_OUT(pout), .I_PERIPH_OE(poe), .I_ANALOG_SEL(ana), .I_EXT_IRQ3(ext3),
    .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_SHARED_EXTERNAL_IRQ_LINE(irq), .O_WAKE(wake));
  fgpio_board u_board (.i_out(pin_out), .i_oe(pin_oe), .i_ext(ext), .o_pin(pin_in));
  task final_report;
  begin
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input [63:0] nm, input [95:0] e, input [95:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // A handshake that never comes ends the run at once.
  task tmo;
  begin
    n_errors = n_errors + 1;
    $display("MISMATCH handshake exp 1 got 0");
    final_report;
  end
  endtask
  task wr(input [31:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
  begin
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    @(posedge clk);
    while ((awready !== 1'b1 || wready !== 1'b1) && k < 50)
    begin
      @(posedge clk);
      k = k + 1;
    end
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k = k + 1;
    end
    bready <= 1'b0;
    if (k >= 50)
      tmo;
    chk("bresp", r, bresp);
  end
  endtask
  task rd(input [31:0] a, input [31:0] e, input [1:0] r);
  begin
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    @(posedge clk);
    while (rvalid !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k = k + 1;
    end
    arvalid <= 1'b0;
    rready <= 1'b0;
    if (k >= 50)
      tmo;
    chk("rdata", e, rdata);
    chk("rresp", r, rresp);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst = 1'b1;
    {awaddr, wdata, araddr, wstrb} = 100'h0;
    {awvalid, wvalid, bready, arvalid, rready, ext3} = 6'h00;
    {ext, psel, pout, poe} = 384'h0;
    ana = 64'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe", 96'h0, pin_oe);
    rd(32'h0, 32'h0, 2'h0);
    wr(32'h0, 32'hff, 4'hf, 2'h0);
    wr(32'h8, 32'ha5, 4'hf, 2'h0);
    repeat (2) @(negedge clk);
    chk("oe", 96'hff, pin_oe);
    chk("out", 96'ha5, pin_out);
    wr(32'hc, 32'hf00, 4'hf, 2'h0);
    wr(32'h10, 32'h5, 4'hf, 2'h0);
    rd(32'h14, 32'hfa0, 2'h0);
    wr(32'h8, 32'h3300, 4'h2, 2'h0);
    rd(32'h14, 32'h33a0, 2'h0);
    wr(32'h4, 32'hf0, 4'hf, 2'h0);
    wr(32'h8, 32'hffffffff, 4'hf, 2'h0);
    rd(32'h14, 32'hffffffaf, 2'h0);
    rd(32'h0, 32'hf, 2'h0);
    rd(32'h108, 32'hff, 2'h0);
    wr(32'h10c, 32'h80, 4'hf, 2'h0);
    rd(32'h14, 32'hffffff2f, 2'h0);
    wr(32'h104, 32'h80, 4'hf, 2'h0);
    wr(32'h124, 32'h1, 4'hf, 2'h0);
    rd(32'h54, 32'h1, 2'h0);
    wr(32'h4, 32'h0, 4'hf, 2'h0);
    ext <= 96'h1234_5600;
    rd(32'h8, 32'h123456af, 2'h0);
    rd(32'h108, 32'hff, 2'h0);
    rd(32'h70, 32'h0, 2'h2);
    wr(32'hc0, 32'h1, 4'hf, 2'h2);
    psel <= 96'h1;
    repeat (3) @(negedge clk);
    chk("pout", 96'hae, pin_out[7:0]);
    chk("poe", 96'hfe, pin_oe[7:0]);
    psel <= 96'h0;
    wr(32'h98, 32'h1, 4'hf, 2'h0);
    ext[64] <= 1'b1;
    repeat (4) @(negedge clk);
    chk("irq", 96'h1, irq);
    chk("wake", 96'h1, wake);
    rd(32'ha0, 32'h1, 2'h0);
    wr(32'ha8, 32'h1, 4'hf, 2'h0);
    ext[64] <= 1'b0;
    repeat (4) @(negedge clk);
    chk("irq", 96'h0, irq);
    wr(32'h9c, 32'h1, 4'hf, 2'h0);
    ext[64] <= 1'b1;
    repeat (2) @(posedge clk);
    ext[64] <= 1'b0;
    repeat (4) @(negedge clk);
    chk("irq", 96'h1, irq);
    rd(32'ha4, 32'h1, 2'h0);
    wr(32'hac, 32'h1, 4'hf, 2'h0);
    wr(32'ha8, 32'h1, 4'hf, 2'h0);
    wr(32'h98, 32'h0, 4'hf, 2'h0);
    ana[9] <= 1'b1;
    wr(32'h1c, 32'h200, 4'hf, 2'h0);
    ext[9] <= 1'b0;
    repeat (4) @(negedge clk);
    chk("analog", 96'h0, irq);
    chk("wake", 96'h0, wake);
    ext3 <= 1'b1;
    repeat (2) @(negedge clk);
    chk("ext3", 96'h1, irq);
    final_report;
  end
endmodule // fgpio_top_tb
